// File: eeprom_pkg.sv
// Shared constants and types for the two-wire EEPROM write path.
// Assumes both ends and the testbench import it.
package eeprom_pkg;
   localparam int PAGE_COUNT = 256;
   localparam int PAGE_BYTES = 64;
   localparam int ADDR_W = 14;
   localparam int OFS_W = 6;
   localparam logic [3:0] DEV_TYPE = 4'ha;
   localparam int TYPE_MSB = 7;
   localparam int TYPE_LSB = 4;
   localparam int SEL_MSB = 3;
   localparam int SEL_LSB = 1;
   localparam int RW_BIT = 0;
   localparam int WA_HI_MSB = 5;
   localparam int PROGRAM_CYCLE_TIME_MS = 5;
   localparam int CLK_MHZ = 100;
   localparam int PROGRAM_CYCLE_CYCLES = PROGRAM_CYCLE_TIME_MS * 1000 * CLK_MHZ;
   localparam int BITS_PER_BYTE = 8;
   localparam int LINK_DIV = 8;
   typedef enum logic [1:0] {CMD_NONE, CMD_WRITE} cmd_t;
endpackage

// File: twi_link_if.sv
// Interface joining the bus master and the EEPROM over the two-wire link.
// Assumes open-drain data; the wire is low when any end enables its driver.
`timescale 1ns/10ps
interface twi_link_if;
   logic scl;
   logic sda_m_oe;
   logic sda_s_oe;
   logic sda;
   assign sda = !(sda_m_oe || sda_s_oe);
   modport device (input scl, input sda, output sda_s_oe);
   modport host (output scl, input sda, output sda_m_oe);
endinterface

// File: sync3.sv
// Three-stage synchroniser with agreement on the last two stages.
// Assumes an asynchronous input and a free clock.
`timescale 1ns/10ps
module sync3 (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic d_i,
   output logic q_o
);
   logic s1_reg;
   logic s2_reg;
   logic s3_reg;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s1_reg <= 1'b1;
         s2_reg <= 1'b1;
         s3_reg <= 1'b1;
         q_o <= 1'b1;
      end else begin
         s1_reg <= d_i;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         if (s2_reg == s3_reg) begin
            q_o <= s3_reg;
         end
      end
   end
endmodule // sync3

// File: eeprom_slave.sv
// EEPROM end: address decode, word address load, page write, program timer.
// Assumes the link clock is the serial clock and mclk_i is the local oscillator.
// Operation
// R1: Array is 256 pages of 64 bytes.
// R2: Device type bits 7..4 must be 1010.
// R3: Bits 3..1 match address select pins.
// R4: Pinless variant: master sends 001 select bits.
// R5: Bit 0 high reads, low writes.
// R6: Match acknowledged; mismatch NACKed, then ignored.
// R7: Master sends two word address bytes.
// R8: First byte gives bits 13..8, ignores 7..6.
// R9: Second byte gives bits 7..0, acknowledged.
// R10: Byte write acknowledged; Stop starts programming.
// R11: Bus ignored while programming runs.
// R12: Up to 64 bytes per page write.
// R13: Every data byte acknowledged; Stop programs.
// R14: Only low six address bits increment.
// R15: Master should avoid overfilling a page.
// R16: Polling address NACKed while busy, ACKed after.
// R17: Array access refused during programming.
// R18: Write-protect high protects whole array.
// R19: Write-protect sampled at Stop only.
// R20: Protected write acknowledged, no programming.
// R21: Sample on rising, drive on falling, MSB first.
// R22: Standby after plain Stop or programming end.
// R23: Program time is a parameterised count.
`timescale 1ns/10ps
module eeprom_slave import eeprom_pkg::*; #(
   parameter int PROG_CYCLES = PROGRAM_CYCLE_CYCLES
) (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic [2:0] addr_sel_i,
   input wire logic write_protect_i,
   twi_link_if.device link,
   output logic busy_o,
   output logic standby_o,
   output logic prog_pulse_o,
   output logic [ADDR_W-1:0] prog_addr_o,
   output logic [7:0] prog_data_o,
   output logic [ADDR_W-1:0] word_addr_o,
   output logic read_sel_o
);
   initial begin
      if (PROG_CYCLES < 1) $error("PROG_CYCLES must be positive");
   end
   // *****************************************
   // Link domain: bit engine on serial clock.
   // *****************************************
   typedef enum {ST_IDLE, ST_DEV, ST_WHI, ST_WLO, ST_DATA, ST_IGNORE} st_t;
   st_t st_reg;
   logic [3:0] bit_reg;
   logic [7:0] shift_reg;
   logic ack_reg;
   logic ack_phase_reg;
   logic [ADDR_W-1:0] waddr_reg;
   logic [7:0] page_mem [PAGE_BYTES];
   logic [PAGE_BYTES-1:0] dirty_reg;
   logic data_seen_reg;
   logic rw_reg;
   logic start_tgl_reg;
   logic stop_tgl_reg;
   logic busy_l1_reg;
   logic busy_l2_reg;
   logic busy_l3_reg;
   logic busy_link_reg;
   logic [7:0] byte_in;
   logic type_ok;
   logic sel_ok;
   logic mem_we;
   assign byte_in = {shift_reg[6:0], link.sda};
   assign type_ok = byte_in[TYPE_MSB:TYPE_LSB] == DEV_TYPE; // see R2
   assign sel_ok = byte_in[SEL_MSB:SEL_LSB] == addr_sel_i; // see R3
   // Start and stop are sampled on data edges while the clock is high.
   always_ff @(negedge link.sda or posedge rst_i) begin
      if (rst_i) begin
         start_tgl_reg <= 1'b0;
      end else if (link.scl) begin
         start_tgl_reg <= !start_tgl_reg;
      end
   end
   always_ff @(posedge link.sda or posedge rst_i) begin
      if (rst_i) begin
         stop_tgl_reg <= 1'b1;
      end else if (link.scl) begin
         stop_tgl_reg <= !stop_tgl_reg;
      end
   end
   logic start_seen_reg;
   logic start_ack_reg;
   assign start_seen_reg = start_tgl_reg != start_ack_reg;
   assign mem_we = st_reg == ST_DATA && bit_reg == 4'(BITS_PER_BYTE - 1)
      && !(start_seen_reg && !ack_phase_reg);
   // The serial clock stands still in reset, so this logic takes rst_i directly.
   always_ff @(posedge link.scl or posedge rst_i) begin // see R21
      if (rst_i) begin
         st_reg <= ST_IDLE;
         bit_reg <= 4'h0;
         shift_reg <= 8'h00;
         waddr_reg <= '0;
         dirty_reg <= '0;
         data_seen_reg <= 1'b0;
         rw_reg <= 1'b0;
         start_ack_reg <= 1'b0;
         busy_l1_reg <= 1'b0;
         busy_l2_reg <= 1'b0;
         busy_l3_reg <= 1'b0;
         busy_link_reg <= 1'b0;
      end else begin
         busy_l1_reg <= busy_o;
         busy_l2_reg <= busy_l1_reg;
         busy_l3_reg <= busy_l2_reg;
         if (busy_l2_reg == busy_l3_reg) begin
            busy_link_reg <= busy_l3_reg;
         end
         start_ack_reg <= start_tgl_reg;
         if (start_seen_reg && !ack_phase_reg) begin
            st_reg <= ST_DEV;
            bit_reg <= 4'h1;
            shift_reg <= {7'h0, link.sda};
            data_seen_reg <= 1'b0;
         end else if (st_reg == ST_IDLE || st_reg == ST_IGNORE) begin
            bit_reg <= 4'h0;
         end else if (bit_reg == 4'(BITS_PER_BYTE)) begin
            bit_reg <= 4'h0;
         end else begin
            shift_reg <= byte_in;
            bit_reg <= bit_reg + 4'h1;
            if (bit_reg == 4'(BITS_PER_BYTE - 1)) begin
               case (st_reg)
                  ST_DEV: begin
                     rw_reg <= byte_in[RW_BIT]; // see R5
                     if (type_ok && sel_ok && !busy_link_reg && !byte_in[RW_BIT]) begin
                        dirty_reg <= '0;
                     end
                     st_reg <= (type_ok && sel_ok && !busy_link_reg)
                        ? (byte_in[RW_BIT] ? ST_IDLE : ST_WHI) : ST_IGNORE; // see R6 R11 R16 R17
                  end
                  ST_WHI: begin
                     waddr_reg[ADDR_W-1:8] <= byte_in[WA_HI_MSB:0]; // see R8
                     st_reg <= ST_WLO;
                  end
                  ST_WLO: begin
                     waddr_reg[7:0] <= byte_in; // see R9
                     st_reg <= ST_DATA;
                  end
                  ST_DATA: begin
                     dirty_reg[waddr_reg[OFS_W-1:0]] <= 1'b1;
                     data_seen_reg <= 1'b1;
                     waddr_reg[OFS_W-1:0] <= waddr_reg[OFS_W-1:0] + 6'h1; // see R14
                  end
                  default: st_reg <= ST_IDLE;
               endcase
            end
         end
      end
   end
   always_ff @(posedge link.scl) begin
      if (mem_we) begin
         page_mem[waddr_reg[OFS_W-1:0]] <= byte_in; // see R12
      end
   end
   // Acknowledge is driven from the falling edge after the eighth bit.
   always_ff @(negedge link.scl or posedge rst_i) begin // see R21
      if (rst_i) begin
         ack_phase_reg <= 1'b0;
         ack_reg <= 1'b0;
      end else begin
         ack_phase_reg <= bit_reg == 4'(BITS_PER_BYTE) && st_reg != ST_IGNORE
            && !(st_reg == ST_IDLE && !rw_reg);
         ack_reg <= bit_reg == 4'(BITS_PER_BYTE) && st_reg != ST_IGNORE
            && st_reg != ST_DEV; // see R6 R10 R13 R20
      end
   end
   assign link.sda_s_oe = ack_reg;
   // *****************************************
   // Local domain: stop handling and program timer.
   // *****************************************
   logic stop_s;
   logic stop_d_reg;
   logic [$clog2(PROG_CYCLES+1)-1:0] timer_reg;
   logic wp_s;
   sync3 u_stop (.clk_i(mclk_i), .rst_i(rst_i), .d_i(stop_tgl_reg), .q_o(stop_s));
   sync3 u_wp (.clk_i(mclk_i), .rst_i(rst_i), .d_i(write_protect_i), .q_o(wp_s));
   logic stop_evt;
   logic write_pending;
   assign stop_evt = stop_s != stop_d_reg;
   assign write_pending = data_seen_reg && st_reg == ST_DATA && !busy_o;
   logic [OFS_W-1:0] prog_idx_reg;
   logic prog_run_reg;
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         stop_d_reg <= 1'b1;
         busy_o <= 1'b0;
         standby_o <= 1'b1;
         timer_reg <= '0;
         prog_pulse_o <= 1'b0;
         prog_addr_o <= '0;
         prog_data_o <= 8'h00;
         prog_idx_reg <= '0;
         prog_run_reg <= 1'b0;
      end else begin
         stop_d_reg <= stop_s;
         prog_pulse_o <= 1'b0;
         if (stop_evt && !busy_o) begin // see R11
            standby_o <= !(write_pending && !wp_s); // see R22
            if (write_pending && !wp_s) begin // see R10 R18 R19 R20
               busy_o <= 1'b1;
               timer_reg <= ($clog2(PROG_CYCLES+1))'(PROG_CYCLES); // see R23
               prog_run_reg <= 1'b1;
               prog_idx_reg <= '0;
            end
         end else if (busy_o) begin
            if (prog_run_reg) begin
               if (dirty_reg[prog_idx_reg]) begin
                  prog_pulse_o <= 1'b1;
                  prog_addr_o <= {waddr_reg[ADDR_W-1:OFS_W], prog_idx_reg}; // see R1
                  prog_data_o <= page_mem[prog_idx_reg];
               end
               prog_idx_reg <= prog_idx_reg + 6'h1;
               prog_run_reg <= prog_idx_reg != 6'(PAGE_BYTES - 1);
            end
            timer_reg <= timer_reg - 1'b1;
            if (timer_reg == 1) begin
               busy_o <= 1'b0;
               standby_o <= 1'b1; // see R22
            end
         end else if (start_seen_reg) begin
            standby_o <= 1'b0;
         end
      end
   end
   assign word_addr_o = waddr_reg;
   assign read_sel_o = rw_reg;
endmodule // eeprom_slave

// File: twi_master.sv
// Bus master end: issues byte and page writes and acknowledge polls.
// Assumes a user that loads one command word at a time.
`timescale 1ns/10ps
module twi_master import eeprom_pkg::*; (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic cmd_valid_i,
   output logic cmd_ready_o,
   input wire logic [2:0] dev_sel_i,
   input wire logic poll_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [7:0] data_i,
   input wire logic [6:0] count_i,
   output logic data_req_o,
   output logic done_o,
   output logic acked_o,
   twi_link_if.host link
);
   // *****************************************
   // Bit sequencer on a divided clock.
   // *****************************************
   typedef enum {M_IDLE, M_START, M_BITS, M_STOP} mst_t;
   mst_t st_reg;
   logic [3:0] div_reg;
   logic [1:0] ph_reg;
   logic [3:0] bit_reg;
   logic [8:0] sh_reg;
   logic [6:0] left_reg;
   logic [1:0] byte_ix_reg;
   logic ok_reg;
   logic sda_s;
   logic tick;
   sync3 u_sda (.clk_i(mclk_i), .rst_i(rst_i), .d_i(link.sda), .q_o(sda_s));
   assign tick = div_reg == 4'(LINK_DIV - 1);
   assign cmd_ready_o = st_reg == M_IDLE;
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         st_reg <= M_IDLE;
         div_reg <= 4'h0;
         ph_reg <= 2'h0;
         bit_reg <= 4'h0;
         sh_reg <= 9'h1ff;
         left_reg <= 7'h0;
         byte_ix_reg <= 2'h0;
         ok_reg <= 1'b0;
         link.scl <= 1'b1;
         link.sda_m_oe <= 1'b0;
         data_req_o <= 1'b0;
         done_o <= 1'b0;
         acked_o <= 1'b0;
      end else begin
         div_reg <= tick ? 4'h0 : div_reg + 4'h1;
         data_req_o <= 1'b0;
         done_o <= 1'b0;
         case (st_reg)
            M_IDLE: begin
               if (cmd_valid_i) begin
                  st_reg <= M_START;
                  // Device address with write direction; pinless parts need 001.
                  sh_reg <= {DEV_TYPE, dev_sel_i, 1'b0, 1'b1}; // see R2 R4 R5
                  left_reg <= poll_i ? 7'h0 : count_i; // see R15
                  byte_ix_reg <= poll_i ? 2'h3 : 2'h0;
                  ok_reg <= 1'b1;
                  ph_reg <= 2'h0;
                  div_reg <= 4'h0;
               end
            end
            M_START: if (tick) begin
               link.sda_m_oe <= 1'b1;
               st_reg <= M_BITS;
               bit_reg <= 4'h0;
            end
            M_BITS: if (tick) begin
               ph_reg <= ph_reg + 2'h1;
               case (ph_reg)
                  2'h0: begin
                     link.scl <= 1'b0;
                  end
                  2'h1: begin
                     link.sda_m_oe <= !sh_reg[8];
                  end
                  2'h2: begin
                     link.scl <= 1'b1;
                  end
                  default: begin
                     sh_reg <= {sh_reg[7:0], 1'b1};
                     bit_reg <= bit_reg + 4'h1;
                     if (bit_reg == 4'(BITS_PER_BYTE)) begin
                        bit_reg <= 4'h0;
                        if (sda_s || byte_ix_reg == 2'h3) begin
                           ok_reg <= !sda_s; // see R16
                           st_reg <= M_STOP;
                        end else begin
                           byte_ix_reg <= byte_ix_reg + 2'h1;
                           case (byte_ix_reg)
                              2'h0: sh_reg <= {2'h0, addr_i[ADDR_W-1:8], 1'b1}; // see R7
                              2'h1: sh_reg <= {addr_i[7:0], 1'b1};
                              default: begin
                                 sh_reg <= {data_i, 1'b1};
                                 data_req_o <= 1'b1;
                                 left_reg <= left_reg - 7'h1;
                                 if (left_reg == 7'h1) byte_ix_reg <= 2'h3;
                                 else byte_ix_reg <= 2'h2;
                              end
                           endcase
                        end
                     end
                  end
               endcase
            end
            M_STOP: if (tick) begin
               ph_reg <= ph_reg + 2'h1;
               case (ph_reg)
                  2'h0: link.scl <= 1'b0;
                  2'h1: link.sda_m_oe <= 1'b1;
                  2'h2: link.scl <= 1'b1;
                  default: begin
                     link.sda_m_oe <= 1'b0; // see R10 R13
                     st_reg <= M_IDLE;
                     done_o <= 1'b1;
                     acked_o <= ok_reg;
                  end
               endcase
            end
            default: st_reg <= M_IDLE;
         endcase
      end
   end
endmodule // twi_master

// File: eeprom_link_asserts.sv
// Checker for the two-wire link and the EEPROM programming timer.
// Assumes it watches the joining interface and slave status on the local clock.
`timescale 1ns/10ps
module eeprom_link_asserts #(
   parameter int PROG_CYCLES = 200
) (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic scl,
   input wire logic sda,
   input wire logic sda_s_oe,
   input wire logic busy_o,
   input wire logic standby_o,
   input wire logic write_protect_i
);
   // ****************************************
   // Helper counters.
   // ****************************************
   localparam int STOP_MAX = 24;
   localparam int OE_MAX = 64;
   logic sda_reg;
   logic [7:0] stop_age_reg;
   logic [7:0] oe_cnt_reg;
   int busy_cnt_reg;
   wire stop_seen = scl && sda && !sda_reg;
   wire [7:0] age_step = {7'h00, stop_age_reg != 8'hff};
   wire [7:0] stop_age_next = stop_seen ? 8'h00 : stop_age_reg + age_step;
   always_ff @(posedge mclk_i) begin
      sda_reg <= sda;
      stop_age_reg <= rst_i ? 8'hff : stop_age_next;
      oe_cnt_reg <= (rst_i || !sda_s_oe) ? 8'h00 : oe_cnt_reg + 8'h01;
      busy_cnt_reg <= (rst_i || !busy_o) ? 0 : busy_cnt_reg + 1;
   end
   // ****************************************
   // Assertions.
   // ****************************************
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (rst_i);
   sequence prog_start_s;
      $rose(busy_o);
   endsequence
   sequence prog_end_s;
      $fell(busy_o);
   endsequence
   oe_scl_low_a: assert property ($changed(sda_s_oe) |-> !scl)
      else $error("slave driver changed while the serial clock was high");
   ack_width_a: assert property (oe_cnt_reg <= OE_MAX)
      else $error("slave held the data line too long");
   busy_quiet_a: assert property (busy_o |-> !sda_s_oe)
      else $error("slave drove the data line while programming");
   busy_standby_a: assert property (busy_o |-> !standby_o)
      else $error("standby shown while programming");
   stop_starts_a: assert property (prog_start_s |-> stop_age_reg <= STOP_MAX)
      else $error("programming began without a recent stop");
   prog_length_a: assert property (prog_end_s |->
      busy_cnt_reg >= PROG_CYCLES - 1 && busy_cnt_reg <= PROG_CYCLES + 1)
      else $error("programming time differs from the set count");
   standby_back_a: assert property (prog_end_s |-> ##[0:4] standby_o)
      else $error("no standby after programming ended");
   wp_gate_a: assert property (prog_start_s |-> !$past(write_protect_i, 8))
      else $error("programming began while write protect was high");
endmodule // eeprom_link_asserts

// File: serial_eeprom_addr_write_path_tb.sv
// Testbench: the master end writes to the EEPROM end over the link.
// Assumes the package, interface, both ends and the checker compile first.
`timescale 1ns/10ps
module serial_eeprom_addr_write_path_tb;
   import eeprom_pkg::*;
   localparam int PROG = 2000;
   logic mclk_i = 1'b1;
   logic rst_i = 1'b0;
   logic [2:0] asel = 3'h5;
   logic wp = 1'b0;
   logic cvalid = 1'b0;
   logic [2:0] dsel = 3'h0;
   logic poll = 1'b0;
   logic [ADDR_W-1:0] addr = '0;
   logic [6:0] count = 7'h01;
   logic [7:0] base = 8'h00;
   logic [7:0] idx = 8'h00;
   logic cready, dreq, done, acked, busy, stby, pulse, rsel;
   logic [ADDR_W-1:0] paddr, waddr;
   logic [7:0] pdata;
   logic [7:0] got [int];
   logic [7:0] want [int];
   int pulses = 0;
   int num_errors = 0;
   int tests_run = 0;
   int i;
   twi_link_if link();
   eeprom_slave #(.PROG_CYCLES(PROG)) eeprom_slave_inst (.mclk_i(mclk_i), .rst_i(rst_i),
      .addr_sel_i(asel), .write_protect_i(wp), .link(link), .busy_o(busy), .standby_o(stby),
      .prog_pulse_o(pulse), .prog_addr_o(paddr), .prog_data_o(pdata), .word_addr_o(waddr),
      .read_sel_o(rsel));
   twi_master twi_master_inst (.mclk_i(mclk_i), .rst_i(rst_i), .cmd_valid_i(cvalid),
      .cmd_ready_o(cready), .dev_sel_i(dsel), .poll_i(poll), .addr_i(addr),
      .data_i(base + idx), .count_i(count), .data_req_o(dreq), .done_o(done),
      .acked_o(acked), .link(link));
   eeprom_link_asserts #(.PROG_CYCLES(PROG)) eeprom_link_asserts_inst (.mclk_i(mclk_i),
      .rst_i(rst_i), .scl(link.scl), .sda(link.sda), .sda_s_oe(link.sda_s_oe),
      .busy_o(busy), .standby_o(stby), .write_protect_i(wp));
   always #5 mclk_i = ~mclk_i;
   always @(negedge mclk_i) begin
      if (dreq === 1'b1) idx <= idx + 8'h01;
      if (pulse === 1'b1) begin
         got[paddr] = pdata;
         pulses++;
      end
   end
   // ****************************************
   // Tasks.
   // ****************************************
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic cmd(input logic [2:0] sel, input logic pl, input logic [ADDR_W-1:0] a,
         input logic [6:0] n, input logic [7:0] d0, input logic prog, input logic ack);
      int k;
      for (k = 0; k < n && prog; k++)
         want[{a[ADDR_W-1:OFS_W], a[OFS_W-1:0] + 6'(k)}] = d0 + 8'(k);
      @(negedge mclk_i);
      dsel = sel;
      poll = pl;
      addr = a;
      count = n;
      base = d0;
      idx = 8'h00;
      cvalid = 1'b1;
      for (k = 0; cready !== 1'b1 && k < 1000; k++) @(negedge mclk_i);
      @(negedge mclk_i);
      cvalid = 1'b0;
      for (k = 0; done !== 1'b1 && k < 40000; k++) @(negedge mclk_i);
      chk("acked", acked, ack);
   endtask
   task automatic wait_busy(input logic lvl);
      int k;
      for (k = 0; busy !== lvl && k < 5000; k++) @(negedge mclk_i);
   endtask
   task automatic drain();
      repeat (20) @(negedge mclk_i);
      wait_busy(1'b0);
      foreach (want[a]) chk("prog_data", got.exists(a) ? got[a] : 8'hxx, want[a]);
      chk("pulses", pulses, want.num());
      want.delete();
      got.delete();
      pulses = 0;
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // ****************************************
   // Tests.
   // ****************************************
   initial begin
      #900000;
      num_errors++;
      final_report();
   end
   initial begin
      @(negedge mclk_i);
      rst_i = 1'b1;
      repeat (16) @(negedge mclk_i);
      rst_i = 1'b0;
      for (i = 0; i < 8; i++) cmd(3'(i), 1'b1, '0, 7'h01, 8'h00, 1'b0, i == 5);
      chk("busy", busy, 1'b0);
      cmd(3'h5, 1'b0, 14'h2abc, 7'h01, 8'h3c, 1'b1, 1'b1);
      chk("read_sel", rsel, 1'b0);
      wait_busy(1'b1);
      chk("standby", stby, 1'b0);
      cmd(3'h5, 1'b1, '0, 7'h01, 8'h00, 1'b0, 1'b0);
      cmd(3'h5, 1'b0, 14'h0100, 7'h01, 8'h77, 1'b0, 1'b0);
      drain();
      chk("standby", stby, 1'b1);
      cmd(3'h5, 1'b1, '0, 7'h01, 8'h00, 1'b0, 1'b1);
      cmd(3'h5, 1'b0, 14'h1240, 7'h40, 8'h80, 1'b1, 1'b1);
      drain();
      cmd(3'h5, 1'b0, 14'h3f3c, 7'h08, 8'h10, 1'b1, 1'b1);
      drain();
      chk("word_addr", waddr, 14'h3f04);
      wp = 1'b1;
      cmd(3'h5, 1'b0, 14'h0200, 7'h02, 8'h55, 1'b0, 1'b1);
      repeat (20) @(negedge mclk_i);
      chk("busy", busy, 1'b0);
      cmd(3'h5, 1'b1, '0, 7'h01, 8'h00, 1'b0, 1'b1);
      drain();
      wp = 1'b0;
      cmd(3'h5, 1'b0, 14'h0300, 7'h01, 8'h99, 1'b1, 1'b1);
      wait_busy(1'b1);
      wp = 1'b1;
      drain();
      wp = 1'b0;
      asel = 3'h1;
      cmd(3'h1, 1'b1, '0, 7'h01, 8'h00, 1'b0, 1'b1);
      final_report();
   end
endmodule // serial_eeprom_addr_write_path_tb
